// >>> design/idle_line_motor_timeout.sv
/*
 * idle_line_motor_timeout: measures idle signal-line time and pulses a
 * motor stop once two mark coincidences pass with no received character.
 * Assumes shaft_tick is a one-clock pulse per intermediate-shaft turn and
 * line_mark is high for marking current, all synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module idle_line_motor_timeout
    import idle_timeout_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic shaft_tick,
    input  wire logic line_mark,
    input  wire logic timer_disable,
    output var  logic motor_stop,
    output var  logic motor_restart,
    output var  logic timer_armed
);
    import idle_timeout_pkg::*;

    // ************************************************************
    // counters
    // ************************************************************
    wheel_if short_w ();
    wheel_if long_w ();
    wire step = shaft_tick && !timer_disable;

    // both counters see the same step, so they can never slip apart
    assign short_w.step = step;
    assign long_w.step  = step;

    mod_wheel #(.STATES(SHORT_WHEEL_STATES)) u_short (.clk(clk), .reset(reset), .w(short_w));
    mod_wheel #(.STATES(LONG_WHEEL_STATES))  u_long  (.clk(clk), .reset(reset), .w(long_w));

    // coincidence is qualified by the tick so it lasts one tick only
    wire coincide = step && short_w.at_mark && long_w.at_mark;

    // ************************************************************
    // line activity
    // ************************************************************
    logic              line_prev_reg;
    logic [OPEN_W-1:0] space_cnt_reg;
    logic [OPEN_W-1:0] space_cnt_next;
    wire               start_edge = line_prev_reg && !line_mark;
    wire               line_open  = (space_cnt_reg == OPEN_W'(OPEN_LINE_CYCLES));

    // spacing counter saturates; any mark clears it
    assign space_cnt_next = line_mark ? OPEN_ZERO :
                            (line_open ? space_cnt_reg : space_cnt_reg + OPEN_ONE);

    // previous level starts at mark, so leaving reset makes no false start edge
    always_ff @(posedge clk) begin
        if (reset) begin
            line_prev_reg <= 1'b1;
            space_cnt_reg <= OPEN_ZERO;
        end else begin
            line_prev_reg <= line_mark;
            space_cnt_reg <= space_cnt_next;
        end
    end

    // ************************************************************
    // timer state
    // ************************************************************
    // latched goes armed on a coincidence; armed goes stopped on the next one
    // unless a character arrives first; stopped goes back to latched once the
    // line has stood open long enough to count as a break
    timer_state_e state_reg;
    timer_state_e state_next;
    wire          fire = (state_reg == ARMED) && coincide && !start_edge;
    wire          wake = (state_reg == STOPPED) && line_open;

    // a line event in the coincidence cycle wins: measurement restarts
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LATCHED: begin
                if (coincide) begin
                    state_next = ARMED;
                end
            end
            ARMED: begin
                if (start_edge) begin
                    state_next = LATCHED;
                end else if (coincide) begin
                    state_next = STOPPED;
                end
            end
            STOPPED: begin
                if (wake) begin
                    state_next = LATCHED;
                end
            end
            default: state_next = LATCHED;
        endcase
    end

    // outputs are registered so the motor side never sees a glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg     <= LATCHED;
            motor_stop    <= 1'b0;
            motor_restart <= 1'b0;
            timer_armed   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            motor_stop    <= fire;
            motor_restart <= wake;
            timer_armed   <= (state_next == ARMED);
        end
    end

    // ************************************************************
    // check helpers
    // ************************************************************
    // widths leave room for two coincidence periods and a long stop
    localparam int                 SINCE_W    = 11;
    localparam int                 GAP_W      = 10;
    localparam logic [SINCE_W-1:0] SINCE_ZERO = 11'h000;
    localparam logic [SINCE_W-1:0] SINCE_ONE  = 11'h001;
    localparam logic [SINCE_W-1:0] SINCE_TOP  = 11'h7FF;
    localparam logic [SINCE_W-1:0] SINCE_LO   = SINCE_W'(CYCLE_TICKS - 1);
    localparam logic [SINCE_W-1:0] SINCE_HI   = SINCE_W'(2 * CYCLE_TICKS - 1);
    localparam logic [GAP_W-1:0]   GAP_ZERO   = 10'h000;
    localparam logic [GAP_W-1:0]   GAP_ONE    = 10'h001;
    localparam logic [GAP_W-1:0]   GAP_FULL   = GAP_W'(CYCLE_TICKS - 1);

    logic [SINCE_W-1:0] since_reg;
    logic [SINCE_W-1:0] since_next;
    logic [GAP_W-1:0]   gap_reg;
    logic [GAP_W-1:0]   gap_next;
    logic               coin_seen_reg;
    wire                meas_restart = start_edge || wake;
    wire                since_full   = (since_reg == SINCE_TOP);

    // steps since the interval reopened; saturating, so a long stop is harmless
    assign since_next = meas_restart ? SINCE_ZERO :
                        ((step && !since_full) ? since_reg + SINCE_ONE : since_reg);
    // steps since the last coincidence, for the period checks
    assign gap_next   = coincide ? GAP_ZERO : (step ? gap_reg + GAP_ONE : gap_reg);

    // check-only state: nothing here reaches a pin, so synthesis prunes it
    always_ff @(posedge clk) begin
        if (reset) begin
            since_reg     <= SINCE_ZERO;
            gap_reg       <= GAP_ZERO;
            coin_seen_reg <= 1'b0;
        end else begin
            since_reg     <= since_next;
            gap_reg       <= gap_next;
            coin_seen_reg <= coin_seen_reg || coincide;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // named steps of the timer, shared by the properties below
    sequence coincide_s;
        coincide;
    endsequence
    sequence fire_s;
        (state_reg == ARMED) ##0 coincide ##0 !start_edge;
    endsequence
    sequence relatch_s;
        (state_reg == ARMED) ##0 start_edge;
    endsequence

    // stop pulse: one cycle, only from armed, only inside the window
    stop_pulse_a: assert property (@(posedge clk) disable iff (reset)
        fire_s |=> motor_stop ##1 !motor_stop) else $error("stop pulse wrong");
    stop_cause_a: assert property (@(posedge clk) disable iff (reset)
        motor_stop |-> $past(state_reg) == ARMED) else $error("stop without arming");
    stop_state_a: assert property (@(posedge clk) disable iff (reset)
        motor_stop |-> state_reg == STOPPED) else $error("stop without stopped state");
    stop_window_a: assert property (@(posedge clk) disable iff (reset)
        fire |-> since_reg >= SINCE_LO && since_reg <= SINCE_HI) else $error("stop outside window");

    // arming and relatching
    arm_on_coin_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == LATCHED) ##0 coincide_s |=> state_reg == ARMED) else $error("no arm");
    latched_waits_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == LATCHED) && !coincide |=> state_reg == LATCHED) else $error("latched timer moved");
    armed_flag_a: assert property (@(posedge clk) disable iff (reset)
        timer_armed == (state_reg == ARMED)) else $error("armed flag wrong");
    relatch_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ARMED && start_edge) |=> state_reg == LATCHED) else $error("no relatch");
    relatch_wins_a: assert property (@(posedge clk) disable iff (reset)
        relatch_s ##0 coincide_s |=> state_reg == LATCHED && !motor_stop) else $error("stop despite line");

    // the first coincidence after reset has no period behind it
    coin_short_a: assert property (@(posedge clk) disable iff (reset)
        coincide |=> !coincide) else $error("coincidence too long");
    coin_period_a: assert property (@(posedge clk) disable iff (reset)
        coincide && coin_seen_reg |-> gap_reg == GAP_FULL) else $error("coincidence period wrong");
    coin_due_a: assert property (@(posedge clk) disable iff (reset)
        step && gap_reg == GAP_FULL |-> coincide) else $error("coincidence missed");

    // disable, restart and line detection
    disable_quiet_a: assert property (@(posedge clk) disable iff (reset)
        timer_disable |-> !coincide) else $error("coincidence while disabled");
    freeze_gap_a: assert property (@(posedge clk) disable iff (reset)
        timer_disable |=> $stable(gap_reg)) else $error("counters moved while disabled");
    restart_a: assert property (@(posedge clk) disable iff (reset)
        motor_restart |-> $past(state_reg) == STOPPED && $past(line_open)) else $error("bad restart");
    restart_pulse_a: assert property (@(posedge clk) disable iff (reset)
        motor_restart |=> !motor_restart) else $error("restart pulse too long");
    edge_once_a: assert property (@(posedge clk) disable iff (reset)
        start_edge |=> !start_edge) else $error("double line event");
    wake_open_a: assert property (@(posedge clk) disable iff (reset)
        line_mark |=> !line_open) else $error("open while marking");
endmodule // idle_line_motor_timeout
`default_nettype wire

// >>> design/idle_timeout_pkg.sv
/*
 * idle_timeout_pkg: constants and state type shared by the idle-line
 * motor timeout block and its coincidence counter.
 * Assumes a single 250 MHz clock and synchronous active-high reset.
 */
package idle_timeout_pkg;
    localparam int   SHORT_WHEEL_STATES = 27;
    localparam int   LONG_WHEEL_STATES  = 27 + 1;
    localparam int   WHEEL_W            = 5;
    localparam logic [WHEEL_W-1:0] WHEEL_MARK = 5'h00;
    localparam logic [WHEEL_W-1:0] WHEEL_ZERO = 5'h00;
    localparam int   CYCLE_TICKS        = 756;
    // open line is declared after this many nanoseconds of steady spacing
    localparam int   OPEN_LINE_NS       = 1000;
    localparam int   CLK_PERIOD_NS      = 4;
    localparam int   OPEN_LINE_CYCLES   = OPEN_LINE_NS / CLK_PERIOD_NS;
    localparam int   OPEN_W             = 9;
    localparam logic [OPEN_W-1:0] OPEN_ZERO = 9'h000;
    localparam logic [OPEN_W-1:0] OPEN_ONE  = 9'h001;
    typedef enum logic [1:0] {LATCHED, ARMED, STOPPED} timer_state_e;
endpackage

// >>> design/wheel_if.sv
/*
 * wheel_if: carries the disable-gated step into each modulo counter and
 * its at-mark flag back out.
 * Assumes both ends share the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface wheel_if;
    logic step;
    logic at_mark;
    modport ctr (input step, output at_mark);
    modport top (output step, input at_mark);
endinterface
`default_nettype wire

// >>> design/mod_wheel.sv
/*
 * mod_wheel: free-running modulo counter with one marked position.
 * Assumes step is a single-cycle pulse per shaft revolution.
 */
`timescale 1ns/1ps
`default_nettype none
module mod_wheel
    import idle_timeout_pkg::*;
#(
    parameter int STATES = SHORT_WHEEL_STATES
) (
    input  wire logic clk,
    input  wire logic reset,
    wheel_if.ctr      w
);
    logic [WHEEL_W-1:0] pos_reg;
    logic [WHEEL_W-1:0] pos_next;
    wire                wrap = (pos_reg == WHEEL_W'(STATES - 1));

    // one step per tick, wrapping at the modulus
    assign pos_next  = w.step ? (wrap ? WHEEL_ZERO : pos_reg + 5'h01) : pos_reg;
    assign w.at_mark = (pos_reg == WHEEL_MARK);

    // reset parks every counter on the mark, so the first step coincides
    always_ff @(posedge clk) begin
        if (reset) begin
            pos_reg <= WHEEL_ZERO;
        end else begin
            pos_reg <= pos_next;
        end
    end

    pos_in_range_a: assert property (@(posedge clk) disable iff (reset)
        pos_reg < WHEEL_W'(STATES)) else $error("wheel position out of range");
    pos_holds_a: assert property (@(posedge clk) disable iff (reset)
        !w.step |=> $stable(pos_reg)) else $error("wheel moved without step");
endmodule // mod_wheel
`default_nettype wire

// >>> tb/motor_ctrl_model.sv
/* motor_ctrl_model: motor control unit at the far side of the timeout.
   Assumes one-cycle stop and resume pulses synchronous to clk. */
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic stop_req,
    input  wire logic resume_req,
    output var  logic motor_on
);
    // motor runs from reset; stop wins if both pulses ever coincide
    always_ff @(posedge clk) begin
        if (reset) motor_on <= 1'h1;
        else if (stop_req) motor_on <= 1'h0;
        else if (resume_req) motor_on <= 1'h1;
    end
endmodule // motor_ctrl_model
`default_nettype wire

// >>> tb/idle_line_motor_timeout_bench.sv
/* idle_line_motor_timeout_bench: directed bench for the idle-line timeout.
   Assumes the motor control model beside the design and a 4 ns clock. */
`timescale 1ns/1ps
`default_nettype none
`define check(g, e, m) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("wrong value %0t %s", $time, m); end end
module idle_line_motor_timeout_bench;
    logic clk = 1'h0, reset = 1'h1, shaft_tick = 1'h0, line_mark = 1'h1, timer_disable = 1'h0;
    logic motor_stop, motor_restart, timer_armed, motor_on;
    int   miscompares = 0, check_count = 0, stops = 0, restarts = 0, cycles = 0;
    always #2 clk = ~clk;
    idle_line_motor_timeout u_dut (.clk(clk), .reset(reset), .shaft_tick(shaft_tick), .line_mark(line_mark),
        .timer_disable(timer_disable), .motor_stop(motor_stop), .motor_restart(motor_restart),
        .timer_armed(timer_armed));
    motor_ctrl_model u_motor (.clk(clk), .reset(reset), .stop_req(motor_stop), .resume_req(motor_restart),
        .motor_on(motor_on));
    // pulse counts; a stretched pulse shows up as an extra count
    always @(posedge clk) begin
        if (motor_stop === 1'h1) stops++;
        if (motor_restart === 1'h1) restarts++;
        cycles++;
        if (cycles == 20000) begin // run needs about 11500
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one revolution: a one-cycle tick, then a quiet cycle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) shaft_tick <= 1'h1;
            @(posedge clk) shaft_tick <= 1'h0;
        end
    endtask
    // let registered pulses land in the counters before judging
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic walk_to_stop();
        `check(timer_armed, 1'h0, "armed at reset")
        ticks(1); settle();
        `check(timer_armed, 1'h1, "no arm")
        ticks(755); settle();
        `check(stops, 0, "early stop")
        ticks(1); settle();
        `check(stops, 1, "stop pulses")
        `check(motor_on, 1'h0, "motor runs")
        `check(timer_armed, 1'h0, "armed after stop")
    endtask
    // hold the line open past the threshold; n is the restart count after it
    task automatic open_line_restart(input int n);
        @(posedge clk) line_mark <= 1'h0;
        repeat (240) @(posedge clk);
        #1;
        `check(restarts, n - 1, "early restart")
        repeat (20) @(posedge clk);
        line_mark <= 1'h1;
        settle();
        `check(restarts, n, "restart pulses")
        `check(motor_on, 1'h1, "motor off")
    endtask
    // a character arrives 100 ticks into the armed wait
    task automatic relatch();
        ticks(755); settle();
        `check(timer_armed, 1'h0, "armed too soon")
        ticks(101);
        #1;
        `check(timer_armed, 1'h1, "not armed")
        @(posedge clk) line_mark <= 1'h0;
        repeat (3) @(posedge clk);
        line_mark <= 1'h1;
        settle();
        `check(timer_armed, 1'h0, "no relatch")
        ticks(655); settle();
        `check(timer_armed, 1'h0, "rearm early")
        ticks(1); settle();
        `check(timer_armed, 1'h1, "counters moved")
        ticks(756); settle();
        `check(stops, 2, "stop window")
    endtask
    task automatic frozen();
        open_line_restart(2);
        @(posedge clk) timer_disable <= 1'h1;
        ticks(1600); settle();
        `check(timer_armed, 1'h0, "armed frozen")
        `check(stops, 2, "stop frozen")
        @(posedge clk) timer_disable <= 1'h0;
        ticks(756); settle();
        `check(timer_armed, 1'h1, "counters ran")
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        walk_to_stop();
        open_line_restart(1);
        relatch();
        frozen();
        print_verdict();
    end
endmodule // idle_line_motor_timeout_bench
`default_nettype wire
